// ---- src/slcm_defs.svh ----
// register map, field positions, reset values and timing counts
`ifndef SLCM_DEFS_SVH
`define SLCM_DEFS_SVH
`define SLCM_CHIP_MODE_ADDR 12'h200
`define SLCM_DECIM_ADDR 12'h201
`define SLCM_LANE_RATE_ADDR 12'h56e
`define SLCM_PLL_STAT_ADDR 12'h56f
`define SLCM_QUICK_ADDR 12'h570
`define SLCM_DEEMPH_FIRST_ADDR 12'h5c1
`define SLCM_DEEMPH_LAST_ADDR 12'h5c5
`define SLCM_MODE_MSB 1
`define SLCM_MODE_LSB 0
`define SLCM_QIGN_BIT 5
`define SLCM_LOW_RATE_BIT 4
`define SLCM_LOCK_BIT 7
`define SLCM_QUICK_L_MSB 7
`define SLCM_QUICK_L_LSB 6
`define SLCM_CHIP_MODE_RST 8'h00
`define SLCM_DECIM_RST 8'h00
`define SLCM_LANE_RATE_RST 8'h00
`define SLCM_QUICK_RST 8'h88
`define SLCM_DEEMPH_RST 8'h00
`define SLCM_NPRIME 16
`define SLCM_CLK_MHZ 200
`define SLCM_SETTLE_NS 100
`define SLCM_SETTLE_CYC ((`SLCM_SETTLE_NS*`SLCM_CLK_MHZ+999)/1000)
`endif

// ---- src/slcm_pkg.sv ----
// types shared by the converter mapping block
package slcm_pkg;
  typedef enum logic [1:0] {
    SLCM_DOWN = 2'b00,
    SLCM_SETTLE = 2'b01,
    SLCM_UP = 2'b11
  } slcm_link_e;
  typedef enum logic [1:0] {
    SLCM_FULL_BW = 2'b00,
    SLCM_ONE_DDC = 2'b01,
    SLCM_TWO_DDC = 2'b10,
    SLCM_FOUR_DDC = 2'b11
  } slcm_chip_mode_e;
  typedef logic [15:0] slcm_word_t;
  typedef logic [127:0] slcm_frame_t;

  // digital_downconverter blocks in use
  function automatic logic [2:0] slcm_ddc_count(slcm_chip_mode_e m);
    case (m)
      SLCM_ONE_DDC: slcm_ddc_count = 3'h1;
      SLCM_TWO_DDC: slcm_ddc_count = 3'h2;
      SLCM_FOUR_DDC: slcm_ddc_count = 3'h4;
      default: slcm_ddc_count = 3'h0;
    endcase
  endfunction : slcm_ddc_count

  // virtual converters on the link
  function automatic logic [3:0] slcm_vc_count(slcm_chip_mode_e m,
                                               logic qign);
    if (m == SLCM_FULL_BW) begin
      slcm_vc_count = 4'h2;
    end else if (qign) begin
      slcm_vc_count = {1'b0, slcm_ddc_count(m)};
    end else begin
      slcm_vc_count = {slcm_ddc_count(m), 1'b0};
    end
  endfunction : slcm_vc_count
endpackage : slcm_pkg

// ---- src/slcm_vc_map.sv ----
// sample streams onto the eight virtual converter slots
`timescale 1ns/1ps
module slcm_vc_map (
  // mode
  input wire slcm_pkg::slcm_chip_mode_e mode_in,
  input wire logic qign_in,
  // streams
  input wire slcm_pkg::slcm_word_t adc_a_in,
  input wire slcm_pkg::slcm_word_t adc_b_in,
  input wire logic [63:0] ddc_i_in,
  input wire logic [63:0] ddc_q_in,
  // slots
  output slcm_pkg::slcm_frame_t frame_out
);
  import slcm_pkg::*;

  always_comb begin
    frame_out = '0;
    if (mode_in == SLCM_FULL_BW) begin
      frame_out[15:0] = adc_a_in;
      frame_out[31:16] = adc_b_in;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (k < int'(slcm_ddc_count(mode_in))) begin
          if (qign_in) begin
            frame_out[16*k +: 16] = ddc_i_in[16*k +: 16];
          end else begin
            frame_out[32*k +: 16] = ddc_i_in[16*k +: 16];
            frame_out[32*k+16 +: 16] = ddc_q_in[16*k +: 16];
          end
        end
      end
    end
  end
endmodule : slcm_vc_map

// ---- src/slcm_pair_buf.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module slcm_pair_buf (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  input wire slcm_pkg::slcm_frame_t in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output slcm_pkg::slcm_frame_t out_data_out,
  input wire logic out_ready_in
);
  import slcm_pkg::*;

  logic out_v_r, out_v_nxt, sk_v_r, sk_v_nxt, rdy_r, rdy_nxt;
  slcm_frame_t out_d_r, out_d_nxt, sk_d_r, sk_d_nxt;
  logic push;

  assign push = in_valid_in & rdy_r;

  always_comb begin
    out_v_nxt = out_v_r;
    out_d_nxt = out_d_r;
    sk_v_nxt = sk_v_r;
    sk_d_nxt = sk_d_r;
    if (!out_v_r || out_ready_in) begin
      if (sk_v_r) begin
        out_v_nxt = 1'b1;
        out_d_nxt = sk_d_r;
        sk_v_nxt = 1'b0;
      end else begin
        out_v_nxt = push;
        if (push) begin
          out_d_nxt = in_data_in;
        end
      end
    end else if (push) begin
      sk_v_nxt = 1'b1;
      sk_d_nxt = in_data_in;
    end
    if (flush_in) begin
      out_v_nxt = 1'b0;
      sk_v_nxt = 1'b0;
    end
    rdy_nxt = !sk_v_nxt;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_v_r <= 1'b0;
      out_d_r <= '0;
      sk_v_r <= 1'b0;
      sk_d_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      out_v_r <= out_v_nxt;
      out_d_r <= out_d_nxt;
      sk_v_r <= sk_v_nxt;
      sk_d_r <= sk_d_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign in_ready_out = rdy_r;
  assign out_valid_out = out_v_r;
  assign out_data_out = out_d_r;
endmodule : slcm_pair_buf

// ---- src/slcm_top.sv ----
// converter mapping and link setup for the serial output link
// How it works
// - serializer pll lock shows read-only at bit 7 of 0x56f.
// - every real or i/q stream is its own virtual converter.
// - i goes to the first converter of a pair, q to the second.
// - up to four downconverters give at most eight converters.
// - slots follow the mode table, leftover slots carry zero.
// - 0x200 bits 1:0 pick the mode, bit 5 picks real output.
// - one link of one, two or four lanes set up through the quick register 0x570.
// - link carries lanes, converters and octets per frame.
// - lane rate is m times n' times 10/8 times fout over lanes.
// - de-emphasis sits in 0x5c1 to 0x5c5 and resets to off.
`timescale 1ns/1ps
`include "slcm_defs.svh"
module slcm_top (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // link power and pll
  input wire logic link_pdn_in,
  input wire logic pll_lock_in,
  // sample streams
  input wire logic smp_valid_in,
  output logic smp_ready_out,
  input wire slcm_pkg::slcm_word_t adc_a_in,
  input wire slcm_pkg::slcm_word_t adc_b_in,
  input wire logic [63:0] ddc_i_in,
  input wire logic [63:0] ddc_q_in,
  // converter frames
  output logic frame_valid_out,
  input wire logic frame_ready_in,
  output slcm_pkg::slcm_frame_t frame_data_out,
  // link setup
  output logic link_up_out,
  output logic [2:0] lanes_out,
  output logic [3:0] convs_out,
  output logic [4:0] octets_out,
  output logic [8:0] lane_rate_mult_out,
  output logic [7:0] decimation_ratio_out,
  output logic low_line_rate_out,
  output logic [39:0] deemph_out
);
  import slcm_pkg::*;

  localparam logic [4:0] SETTLE_CYC = 5'(`SLCM_SETTLE_CYC);

  // lanes from the quick setup code
  function automatic logic [2:0] lanes_of(logic [7:0] q);
    case (q[`SLCM_QUICK_L_MSB:`SLCM_QUICK_L_LSB])
      2'h0: lanes_of = 3'h1;
      2'h1: lanes_of = 3'h2;
      default: lanes_of = 3'h4;
    endcase
  endfunction : lanes_of

  // octets per frame, one sample word per converter
  function automatic logic [4:0] octets_of(logic [3:0] m,
                                           logic [2:0] l);
    logic [6:0] oct;
    oct = 7'(({3'h0, m} * 7'(`SLCM_NPRIME / 8)) / {4'h0, l});
    octets_of = (oct == 7'h0) ? 5'h1 : oct[4:0];
  endfunction : octets_of

  // lane rate in half units of fout
  function automatic logic [8:0] rate_of(logic [3:0] m, logic [2:0] l);
    logic [11:0] num;
    num = 12'({8'h0, m} * 12'(`SLCM_NPRIME * 10 * 2 / 8));
    rate_of = 9'(num / {9'h0, l});
  endfunction : rate_of

  // register file
  logic [7:0] mode_reg_r, mode_reg_nxt;
  logic [7:0] decim_reg_r, decim_reg_nxt;
  logic [7:0] rate_reg_r, rate_reg_nxt;
  logic [7:0] quick_reg_r, quick_reg_nxt;
  logic [39:0] deemph_r, deemph_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [2:0] de_idx;

  assign de_idx = 3'(reg_addr_in - `SLCM_DEEMPH_FIRST_ADDR);

  always_comb begin
    mode_reg_nxt = mode_reg_r;
    decim_reg_nxt = decim_reg_r;
    rate_reg_nxt = rate_reg_r;
    quick_reg_nxt = quick_reg_r;
    deemph_nxt = deemph_r;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `SLCM_CHIP_MODE_ADDR: mode_reg_nxt = reg_wdata_in;
        `SLCM_DECIM_ADDR: decim_reg_nxt = reg_wdata_in;
        `SLCM_LANE_RATE_ADDR: rate_reg_nxt = reg_wdata_in;
        `SLCM_QUICK_ADDR: quick_reg_nxt = reg_wdata_in;
        default: begin
          if (reg_addr_in >= `SLCM_DEEMPH_FIRST_ADDR &&
              reg_addr_in <= `SLCM_DEEMPH_LAST_ADDR) begin
            deemph_nxt[8*de_idx +: 8] = reg_wdata_in;
          end
        end
      endcase
    end
  end

  // link state
  slcm_link_e state_r, state_nxt;
  logic [4:0] settle_r, settle_nxt;
  logic lock_r, lock_nxt;
  slcm_chip_mode_e act_mode_r, act_mode_nxt;
  logic act_qign_r, act_qign_nxt;
  logic [2:0] lanes_r, lanes_nxt;
  logic [3:0] convs_r, convs_nxt;
  logic [4:0] octets_r, octets_nxt;
  logic [8:0] mult_r, mult_nxt;
  logic [7:0] decim_r, decim_nxt;
  logic low_r, low_nxt;
  logic up_r, up_nxt;
  logic [3:0] m_new;

  assign m_new = slcm_vc_count(
    slcm_chip_mode_e'(mode_reg_r[`SLCM_MODE_MSB:`SLCM_MODE_LSB]),
    mode_reg_r[`SLCM_QIGN_BIT]);

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    lock_nxt = pll_lock_in;
    act_mode_nxt = act_mode_r;
    act_qign_nxt = act_qign_r;
    lanes_nxt = lanes_r;
    convs_nxt = convs_r;
    octets_nxt = octets_r;
    mult_nxt = mult_r;
    decim_nxt = decim_r;
    low_nxt = low_r;
    case (state_r)
      SLCM_DOWN: begin
        settle_nxt = 5'h0;
        if (!link_pdn_in) begin
          state_nxt = SLCM_SETTLE;
          act_mode_nxt = slcm_chip_mode_e'(
            mode_reg_r[`SLCM_MODE_MSB:`SLCM_MODE_LSB]);
          act_qign_nxt = mode_reg_r[`SLCM_QIGN_BIT];
          lanes_nxt = lanes_of(quick_reg_r);
          convs_nxt = m_new;
          octets_nxt = octets_of(m_new, lanes_of(quick_reg_r));
          mult_nxt = rate_of(m_new, lanes_of(quick_reg_r));
          decim_nxt = decim_reg_r;
          low_nxt = rate_reg_r[`SLCM_LOW_RATE_BIT];
        end
      end
      SLCM_SETTLE: begin
        if (link_pdn_in) begin
          state_nxt = SLCM_DOWN;
        end else if (!lock_r) begin
          settle_nxt = 5'h0;
        end else if (settle_r == SETTLE_CYC - 5'h1) begin
          state_nxt = SLCM_UP;
        end else begin
          settle_nxt = settle_r + 5'h1;
        end
      end
      SLCM_UP: begin
        if (link_pdn_in) begin
          state_nxt = SLCM_DOWN;
        end else if (!lock_r) begin
          settle_nxt = 5'h0;
          state_nxt = SLCM_SETTLE;
        end
      end
      default: begin
        state_nxt = SLCM_DOWN;
      end
    endcase
    // running flag kept in its own flop
    up_nxt = (state_nxt == SLCM_UP);
  end

  // register reads
  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = reg_rd_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `SLCM_CHIP_MODE_ADDR: rdata_nxt = mode_reg_r;
        `SLCM_DECIM_ADDR: rdata_nxt = decim_reg_r;
        `SLCM_LANE_RATE_ADDR: rdata_nxt = rate_reg_r;
        `SLCM_PLL_STAT_ADDR: rdata_nxt[`SLCM_LOCK_BIT] = lock_r;
        `SLCM_QUICK_ADDR: rdata_nxt = quick_reg_r;
        default: begin
          if (reg_addr_in >= `SLCM_DEEMPH_FIRST_ADDR &&
              reg_addr_in <= `SLCM_DEEMPH_LAST_ADDR) begin
            rdata_nxt = deemph_r[8*de_idx +: 8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg_r <= `SLCM_CHIP_MODE_RST;
      decim_reg_r <= `SLCM_DECIM_RST;
      rate_reg_r <= `SLCM_LANE_RATE_RST;
      quick_reg_r <= `SLCM_QUICK_RST;
      deemph_r <= {5{`SLCM_DEEMPH_RST}};
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      mode_reg_r <= mode_reg_nxt;
      decim_reg_r <= decim_reg_nxt;
      rate_reg_r <= rate_reg_nxt;
      quick_reg_r <= quick_reg_nxt;
      deemph_r <= deemph_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= SLCM_DOWN;
      settle_r <= 5'h0;
      lock_r <= 1'b0;
      act_mode_r <= SLCM_FULL_BW;
      act_qign_r <= 1'b0;
      lanes_r <= 3'h1;
      convs_r <= 4'h2;
      octets_r <= 5'h1;
      mult_r <= 9'h0;
      decim_r <= 8'h00;
      low_r <= 1'b0;
      up_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      lock_r <= lock_nxt;
      act_mode_r <= act_mode_nxt;
      act_qign_r <= act_qign_nxt;
      lanes_r <= lanes_nxt;
      convs_r <= convs_nxt;
      octets_r <= octets_nxt;
      mult_r <= mult_nxt;
      decim_r <= decim_nxt;
      low_r <= low_nxt;
      up_r <= up_nxt;
    end
  end

  // data path
  slcm_frame_t map_frame;
  logic buf_ready;
  logic link_up;

  assign link_up = up_r;

  slcm_vc_map u_map (
    .mode_in(act_mode_r),
    .qign_in(act_qign_r),
    .adc_a_in(adc_a_in),
    .adc_b_in(adc_b_in),
    .ddc_i_in(ddc_i_in),
    .ddc_q_in(ddc_q_in),
    .frame_out(map_frame)
  );

  slcm_pair_buf u_buf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .flush_in(!link_up),
    .in_valid_in(smp_valid_in & link_up),
    .in_data_in(map_frame),
    .in_ready_out(buf_ready),
    .out_valid_out(frame_valid_out),
    .out_data_out(frame_data_out),
    .out_ready_in(frame_ready_in)
  );

  assign smp_ready_out = buf_ready;
  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign link_up_out = up_r;
  assign lanes_out = lanes_r;
  assign convs_out = convs_r;
  assign octets_out = octets_r;
  assign lane_rate_mult_out = mult_r;
  assign decimation_ratio_out = decim_r;
  assign low_line_rate_out = low_r;
  assign deemph_out = deemph_r;
endmodule : slcm_top

// ---- sim/slcm_top_props.sv ----
// assertion checker for the converter mapping block
`timescale 1ns/1ps
module slcm_top_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic link_pdn_in,
  input wire logic pll_lock_in,
  input wire logic frame_valid_out,
  input wire logic frame_ready_in,
  input wire slcm_pkg::slcm_frame_t frame_data_out,
  input wire logic link_up_out,
  input wire logic [2:0] lanes_out,
  input wire logic [3:0] convs_out,
  input wire logic [4:0] octets_out,
  input wire logic [8:0] lane_rate_mult_out
);
  import slcm_pkg::*;
  logic [5:0] lock_cnt_r;
  logic [5:0] lock_cnt_nxt;
  // cycles of lock with the link powered
  always_comb begin
    lock_cnt_nxt = lock_cnt_r;
    if (link_pdn_in || !pll_lock_in) lock_cnt_nxt = 6'h00;
    else if (lock_cnt_r != 6'h3f) lock_cnt_nxt = lock_cnt_r + 6'h01;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) lock_cnt_r <= 6'h00;
    else lock_cnt_r <= lock_cnt_nxt;
  end
  default clocking dcb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_rd_quiet: assert property (!reg_rd_in |=> !reg_rvalid_out &&
    reg_rdata_out == 8'h00) else $error("read data without read");
  chk_lock_bit: assert property (reg_rd_in && reg_addr_in == 12'h56f &&
    $stable(pll_lock_in) |=> reg_rdata_out == {$past(pll_lock_in), 7'h00})
    else $error("lock bit wrong");
  chk_up_after: assert property ($rose(link_up_out) |->
    lock_cnt_r inside {[20:22]}) else $error("link up too early or late");
  chk_lock_loss: assert property ($fell(pll_lock_in) |->
    ##2 !link_up_out [*8]) else $error("link up without lock");
  chk_down_stops: assert property (link_pdn_in |=> !link_up_out)
    else $error("link up while powered down");
  chk_setup_frozen: assert property (link_up_out &&
    $past(link_up_out) |-> $stable(lanes_out) && $stable(convs_out) &&
    $stable(octets_out)) else $error("setup changed on running link");
  chk_octets_rel: assert property (link_up_out |-> 32'(octets_out) ==
    ((2 * convs_out / lanes_out > 0) ? 2 * convs_out / lanes_out : 1))
    else $error("octets per frame wrong");
  chk_rate_mult: assert property (link_up_out |->
    32'(lane_rate_mult_out) == 40 * convs_out / lanes_out)
    else $error("lane rate multiple wrong");
  chk_frame_hold: assert property (link_up_out && frame_valid_out &&
    !frame_ready_in |=> frame_valid_out && $stable(frame_data_out))
    else $error("frame lost");
  chk_no_frame: assert property (!link_up_out && !frame_valid_out |=>
    !frame_valid_out) else $error("frame while link down");
endmodule : slcm_top_props
bind slcm_top slcm_top_props chk_u (.core_clk_in, .rst_n_in, .reg_addr_in,
  .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .link_pdn_in, .pll_lock_in,
  .frame_valid_out, .frame_ready_in, .frame_data_out, .link_up_out,
  .lanes_out, .convs_out, .octets_out, .lane_rate_mult_out);

// ---- sim/slcm_rx_model.sv ----
// frame receiver model on the far side of the link
`timescale 1ns/1ps
module slcm_rx_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // stall command
  input wire logic stall_in,
  // frames
  input wire logic frame_valid_in,
  input wire slcm_pkg::slcm_frame_t frame_data_in,
  output logic frame_ready_out
);
  import slcm_pkg::*;
  slcm_frame_t rx_q[$];
  // takes a frame at each edge with valid and ready
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_ready_out <= 1'b0;
    end else begin
      frame_ready_out <= !stall_in;
      if (frame_valid_in && frame_ready_out) rx_q.push_back(frame_data_in);
    end
  end
endmodule : slcm_rx_model

// ---- sim/tb.sv ----
// self-checking bench for the converter mapping block
`timescale 1ns/1ps
`include "slcm_defs.svh"
module tb;
  import slcm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pdn = 1'b1;
  logic lock = 1'b0, sv = 1'b0, stall = 1'b0, fr, rvalid, sr, fv, up, low;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata, dec;
  slcm_word_t a = 16'h0000, b = 16'hb1b1;
  logic [63:0] di = 64'h1313_1212_1111_1010, dq = 64'h2323_2222_2121_2020;
  slcm_frame_t fd;
  logic [2:0] lanes;
  logic [3:0] convs;
  logic [4:0] octs;
  logic [8:0] mult;
  logic [39:0] deemph;
  int n_mismatch = 0, comparisons = 0;
  slcm_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .link_pdn_in(pdn),
    .pll_lock_in(lock), .smp_valid_in(sv), .smp_ready_out(sr),
    .adc_a_in(a), .adc_b_in(b), .ddc_i_in(di), .ddc_q_in(dq),
    .frame_valid_out(fv), .frame_ready_in(fr), .frame_data_out(fd),
    .link_up_out(up), .lanes_out(lanes), .convs_out(convs),
    .octets_out(octs), .lane_rate_mult_out(mult),
    .decimation_ratio_out(dec), .low_line_rate_out(low), .deemph_out(deemph));
  slcm_rx_model rx_u (.core_clk_in(clk), .rst_n_in(rst_n), .stall_in(stall),
    .frame_valid_in(fv), .frame_data_in(fd), .frame_ready_out(fr));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic give_up;
    n_mismatch++;
    close_out();
  endtask : give_up
  task automatic wr_reg(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] ad, input logic [7:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp({rvalid, rdata}, {1'b1, exp});
    @(posedge clk);
  endtask : rd_chk
  task automatic wait_up;
    for (int k = 0; up !== 1'b1; k++) begin
      if (k == 60) give_up();
      @(posedge clk);
    end
  endtask : wait_up
  task automatic wait_rx(input int n);
    for (int k = 0; rx_u.rx_q.size() < n; k++) begin
      if (k == 60) give_up();
      @(posedge clk);
    end
  endtask : wait_rx
  task automatic send_set(input slcm_word_t v);
    a <= v;
    sv <= 1'b1;
    for (int k = 0; k < 61; k++) begin
      if (k == 60) give_up();
      @(posedge clk);
      if (sr === 1'b1 && up === 1'b1) break;
    end
  endtask : send_set
  function automatic slcm_frame_t exp_frame(input logic [1:0] md,
                                            input logic qi);
    slcm_frame_t f;
    f = '0;
    if (md == 2'h0) f[31:0] = {b, a};
    for (int k = 0; k < ((md == 2'h3) ? 4 : md); k++) begin
      if (qi) f[16*k +: 16] = di[16*k +: 16];
      else f[32*k +: 32] = {dq[16*k +: 16], di[16*k +: 16]};
    end
    return f;
  endfunction : exp_frame
  task automatic reg_run;
    rd_chk(`SLCM_CHIP_MODE_ADDR, 8'h00);
    cmp({up, lanes, convs, octs}, {1'b0, 3'h1, 4'h2, 5'h1});
    rd_chk(`SLCM_LANE_RATE_ADDR, 8'h00);
    rd_chk(`SLCM_QUICK_ADDR, 8'h88);
    for (int k = 0; k < 5; k++) rd_chk(12'h5c1 + 12'(k), 8'h00);
    cmp(deemph, 40'h00_0000_0000);
    rd_chk(12'h300, 8'h00);
    wr_reg(`SLCM_PLL_STAT_ADDR, 8'h7f);
    rd_chk(`SLCM_PLL_STAT_ADDR, 8'h00);
    lock <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`SLCM_PLL_STAT_ADDR, 8'h80);
    wr_reg(12'h5c3, 8'h5a);
    rd_chk(12'h5c3, 8'h5a);
    cmp(deemph, 40'h00_005a_0000);
    wr_reg(`SLCM_DECIM_ADDR, 8'h08);
    rd_chk(`SLCM_DECIM_ADDR, 8'h08);
  endtask : reg_run
  task automatic map_case(input logic [1:0] md, input logic qi,
                          input logic [7:0] qk);
    int m, l, rate;
    logic lo;
    m = (md == 2'h0) ? 2 : ((md == 2'h3) ? 4 : md) * (qi ? 1 : 2);
    l = (qk[7:6] == 2'h0) ? 1 : ((qk[7:6] == 2'h1) ? 2 : 4);
    rate = (40 * m / l) * 3125 / 20; // fout 312.5 MHz, in Mbps
    lo = (rate < 6250);
    @(posedge clk);
    pdn <= 1'b1;
    wr_reg(`SLCM_CHIP_MODE_ADDR, {2'h0, qi, 3'h0, md});
    wr_reg(`SLCM_DECIM_ADDR, 8'h04);
    wr_reg(`SLCM_LANE_RATE_ADDR, lo ? 8'h10 : 8'h00);
    wr_reg(`SLCM_QUICK_ADDR, qk);
    pdn <= 1'b0;
    wait_up();
    cmp(convs, m);
    cmp(lanes, l);
    cmp(octs, (2 * m / l > 0) ? 2 * m / l : 1);
    cmp(mult, 40 * m / l);
    cmp({dec, low}, {8'h04, lo});
    send_set(16'ha0a0);
    sv <= 1'b0;
    wait_rx(1);
    cmp(rx_u.rx_q.pop_front(), exp_frame(md, qi));
    wr_reg(`SLCM_CHIP_MODE_ADDR, 8'h03);
    wr_reg(`SLCM_QUICK_ADDR, 8'h00);
    cmp({convs, lanes, dec}, {m[3:0], l[2:0], 8'h04});
  endtask : map_case
  task automatic stall_run;
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    send_set(16'h0101);
    send_set(16'h0202);
    a <= 16'h0303;
    repeat (4) @(posedge clk);
    cmp({sr, fv}, 2'b01);
    stall <= 1'b0;
    send_set(16'h0303);
    sv <= 1'b0;
    wait_rx(3);
    for (int k = 1; k < 4; k++) begin
      cmp(rx_u.rx_q.pop_front(), {96'h0, b, 8'(k), 8'(k)});
    end
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    cmp(up, 1'b0);
    lock <= 1'b1;
    wait_up();
    pdn <= 1'b1;
    repeat (2) @(posedge clk);
    cmp({up, fv}, 2'b00);
  endtask : stall_run
  logic [1:0] md_t [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
  logic [7:0] qk_t [8] = '{8'h88, 8'h01, 8'h49, 8'h49, 8'h91, 8'h91,
                           8'h9a, 8'h88};
  logic [7:0] qi_t = 8'haa;
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reg_run();
    for (int k = 0; k < 8; k++) map_case(md_t[k], qi_t[k], qk_t[k]);
    stall_run();
    close_out();
  end
endmodule : tb
